// file: smm_monitor_mode.v
// Monitor-mode command interpreter for an eight-channel squib driver.
//
// Contract
// - Frame with top bits 11 is a monitor message; bits 12..9 ignored.
// - Odd parity over all sixteen bits, carried in bit 13; host sets it.
// - Message bit 8 picks status: 0 success flags, 1 active OR success.
// - In OR reporting a status bit stays 1 from deployment until flag clear.
// - Deployment status bit is captured at chip select rising edge.
// - A change of report select shows immediately in the next status.
// - Success flag sets when a channel's deploy period expires.
// - Set success flag rejects new deployment commands for that channel.
// - Monitor bits 7..0 set to 1 clear that channel's success flag.
// - Responses are 16 bits, sent most significant bit first.
// - Response bits 15:14 give type: register, command, diagnostic, status.
// - The response in a frame reflects the previous frame.
// - Diagnostic response bit 7 reads 1 when monitored channel's below-ground comparator is set.
// - Diagnostic bit 7 at 0 puts analog monitor output in high impedance.
// - Diagnostic bits 6..4 select monitored channel 0 to 7.
// - Diagnostic response follows in the next transfer regardless of write bit.
`timescale 1ns/1ps
`include "smm_defines.vh"
module smm_monitor_mode #(
   parameter CHANNELS      = 8,
   parameter DEPLOY_CYCLES = `SMM_DEPLOY_CYCLES
) (
   // Clock and reset.
   input  wire                core_clk,
   input  wire                rst_n,
   // SPI link pins.
   input  wire                sclk,
   input  wire                csDeploy_n,
   input  wire                mosi,
   output wire                miso,
   output wire                misoEn,
   // Deployment requests from the command decoder.
   input  wire [CHANNELS-1:0] deployRequest,
   // Analog comparator results, from the analog front end.
   input  wire [CHANNELS-1:0] sqlBelowGnd,
   input  wire                sqhAboveBat,
   input  wire                overCurrent,
   // Deployment state, report select, analog monitor controls and parity fault.
   output reg  [CHANNELS-1:0] deployActive,
   output reg  [CHANNELS-1:0] deploySuccess,
   output reg                 reportOr,
   output reg                 analogMonitorEn,
   output reg  [2:0]          monitorChannel,
   output reg                 parityFault
);
   wire [15:0] rxWord;
   wire        frameDone;
   wire        csRise;
   reg  [15:0] txWord;
   reg  [CHANNELS-1:0] deployStatus;
   reg  [CHANNELS-1:0] deployStart;
   reg  [1:0]  lastMode;
   reg  [2:0]  diagSel;
   reg  [31:0] deployTimer [0:CHANNELS-1];
   reg  [CHANNELS-1:0] sqlSync1;
   reg  [CHANNELS-1:0] sqlSync2;
   reg  [1:0]  batSync;
   reg  [1:0]  ocSync;
   reg  [CHANNELS-1:0] reqSync1;
   reg  [CHANNELS-1:0] reqSync2;
   reg  [CHANNELS-1:0] reqPrev;
   integer     i;

   function oddParityOk;
      input [15:0] w;
      begin
         oddParityOk = ^w;
      end
   endfunction

   wire        parityOk  = oddParityOk(rxWord);
   wire [1:0]  rxMode    = rxWord[`SMM_MODE_HI:`SMM_MODE_LO];
   wire        isMonitor = frameDone && rxMode == `SMM_MODE_MONITOR;
   wire        isDiag    = frameDone && rxMode == `SMM_MODE_DIAG;
   wire [CHANNELS-1:0] reqEdge = reqSync2 & ~reqPrev;

   smm_spi_shift u_shift (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .sclk       (sclk),
      .csDeploy_n (csDeploy_n),
      .mosi       (mosi),
      .miso       (miso),
      .misoEn     (misoEn),
      .txWord     (txWord),
      .rxWord     (rxWord),
      .frameDone  (frameDone),
      .csRise     (csRise)
   );

   // ========================================
   // Input synchronisers for asynchronous analog and request levels.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         sqlSync1 <= {CHANNELS{1'b0}};
         sqlSync2 <= {CHANNELS{1'b0}};
         batSync  <= 2'h0;
         ocSync   <= 2'h0;
         reqSync1 <= {CHANNELS{1'b0}};
         reqSync2 <= {CHANNELS{1'b0}};
         reqPrev  <= {CHANNELS{1'b0}};
      end else begin
         sqlSync1 <= sqlBelowGnd;
         sqlSync2 <= sqlSync1;
         batSync  <= {batSync[0], sqhAboveBat};
         ocSync   <= {ocSync[0], overCurrent};
         reqSync1 <= deployRequest;
         reqSync2 <= reqSync1;
         reqPrev  <= reqSync2;
      end
   end

   // ========================================
   // Deployment timers and success flags.
   always @* begin
      // A channel with its success flag set refuses a new deployment.
      deployStart = reqEdge & ~deployActive & ~deploySuccess;
   end

   always @(posedge core_clk) begin
      if (!rst_n) begin
         deployActive  <= {CHANNELS{1'b0}};
         deploySuccess <= `SMM_FLAGS_RESET;
         reportOr      <= `SMM_REPORT_RESET;
         parityFault   <= 1'b0;
         for (i = 0; i < CHANNELS; i = i + 1)
            deployTimer[i] <= 32'h00000000;
      end else begin
         if (isMonitor) begin
            parityFault <= ~parityOk;
            if (parityOk) begin
               reportOr <= rxWord[`SMM_REPORT_BIT];
            end
         end
         for (i = 0; i < CHANNELS; i = i + 1) begin
            // Expiry wins over a clear arriving in the same cycle.
            if (isMonitor && parityOk && rxWord[i]) begin
               deploySuccess[i] <= 1'b0;
            end
            if (deployStart[i]) begin
               deployActive[i] <= 1'b1;
               deployTimer[i]  <= DEPLOY_CYCLES - 1;
            end else if (deployActive[i]) begin
               if (deployTimer[i] == 32'h00000000) begin
                  deployActive[i]  <= 1'b0;
                  deploySuccess[i] <= 1'b1;
               end else begin
                  deployTimer[i] <= deployTimer[i] - 32'h00000001;
               end
            end
         end
      end
   end

   // ========================================
   // Diagnostic settings, status capture and response build.
   // The response mode is latched at the frame end so the response lags by one transfer.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         deployStatus    <= {CHANNELS{1'b0}};
         lastMode        <= `SMM_MODE_REGISTER;
         analogMonitorEn <= 1'b0;
         monitorChannel  <= 3'h0;
         diagSel         <= 3'h0;
         txWord          <= `SMM_RESP_RESET;
      end else begin
         if (csRise) begin
            deployStatus <= deployActive;
         end
         if (isDiag && parityOk && rxWord[`SMM_WRITE_BIT]) begin
            analogMonitorEn <= rxWord[`SMM_ANALOG_MONITOR_OUT_EN_BIT];
            monitorChannel  <= rxWord[`SMM_MON_SEL_HI:`SMM_MON_SEL_LO];
            diagSel         <= rxWord[`SMM_MON_SEL_HI:`SMM_MON_SEL_LO];
         end
         if (frameDone) begin
            lastMode <= rxMode;
         end
         // Rebuilt every cycle so a report-select change is never stale.
         case (lastMode)
            `SMM_MODE_MONITOR: begin
               txWord <= {`SMM_MODE_MONITOR, 6'h00,
                          reportOr ? (deployStatus | deployActive | deploySuccess)
                                   : deploySuccess};
            end
            `SMM_MODE_DIAG: begin
               txWord <= {`SMM_MODE_DIAG, batSync[1], 5'h00,
                          sqlSync2[diagSel], 3'h0, ocSync[1], 3'h0};
            end
            `SMM_MODE_COMMAND: begin
               txWord <= {`SMM_MODE_COMMAND, 6'h00, reqSync2};
            end
            default: begin
               txWord <= `SMM_RESP_RESET;
            end
         endcase
      end
   end
endmodule // smm_monitor_mode

// file: smm_defines.vh
// Constants for the squib monitor-mode SPI block.
`ifndef SMM_DEFINES_VH
`define SMM_DEFINES_VH
`define SMM_FRAME_BITS      16
`define SMM_CHANNELS        8
`define SMM_MODE_HI         15
`define SMM_MODE_LO         14
`define SMM_PARITY_BIT      13
`define SMM_WRITE_BIT       12
`define SMM_REPORT_BIT      8
`define SMM_ANALOG_MONITOR_OUT_EN_BIT     7
`define SMM_MON_SEL_HI      6
`define SMM_MON_SEL_LO      4
`define SMM_MODE_REGISTER   2'h0
`define SMM_MODE_COMMAND    2'h1
`define SMM_MODE_DIAG       2'h2
`define SMM_MODE_MONITOR    2'h3
`define SMM_RESP_RESET      16'h0000
`define SMM_REPORT_RESET    1'b0
`define SMM_FLAGS_RESET     8'h00
`define SMM_DEPLOY_PERIOD_US 2000
`define SMM_CLK_MHZ         20
`define SMM_DEPLOY_CYCLES   (`SMM_DEPLOY_PERIOD_US * `SMM_CLK_MHZ)
`endif

// file: smm_spi_shift.v
// SPI slave shifter: samples link pins, shifts 16-bit frames in and out.
`timescale 1ns/1ps
`include "smm_defines.vh"
module smm_spi_shift (
   // Clock and reset.
   input  wire        core_clk,
   input  wire        rst_n,
   // Link pins.
   input  wire        sclk,
   input  wire        csDeploy_n,
   input  wire        mosi,
   output reg         miso,
   output reg         misoEn,
   // Frame side.
   input  wire [15:0] txWord,
   output reg  [15:0] rxWord,
   output reg         frameDone,
   output reg         csRise
);
   reg [2:0]  sclkSync;
   reg [2:0]  csSync;
   reg [1:0]  mosiSync;
   reg [15:0] shiftIn;
   reg [15:0] shiftOut;
   reg [4:0]  bitCount;
   wire sclkRise = sclkSync[1] & ~sclkSync[2];
   wire sclkFall = ~sclkSync[1] & sclkSync[2];
   wire csFall   = ~csSync[1] & csSync[2];
   wire csEdgeUp = csSync[1] & ~csSync[2];
   // ========================================
   // Pin synchronisers and shifting.
   // Edge detectors look only at the second and third stages.
   always @(posedge core_clk) begin
      if (!rst_n) begin
         sclkSync  <= 3'h0;
         csSync    <= 3'h7;
         mosiSync  <= 2'h0;
         shiftIn   <= 16'h0000;
         shiftOut  <= 16'h0000;
         bitCount  <= 5'h00;
         rxWord    <= 16'h0000;
         frameDone <= 1'b0;
         csRise    <= 1'b0;
         miso      <= 1'b0;
         misoEn    <= 1'b0;
      end else begin
         sclkSync  <= {sclkSync[1:0], sclk};
         csSync    <= {csSync[1:0], csDeploy_n};
         mosiSync  <= {mosiSync[0], mosi};
         frameDone <= 1'b0;
         csRise    <= csEdgeUp;
         if (csFall) begin
            shiftOut <= txWord;
            miso     <= txWord[15];
            misoEn   <= 1'b1;
            bitCount <= 5'h00;
         end else if (!csSync[2]) begin
            if (sclkRise) begin
               shiftIn  <= {shiftIn[14:0], mosiSync[1]};
               bitCount <= bitCount + 5'h01;
            end
            if (sclkFall && bitCount != 5'h00) begin
               shiftOut <= {shiftOut[14:0], 1'b0};
               miso     <= shiftOut[14];
            end
         end
         if (csEdgeUp) begin
            misoEn <= 1'b0;
            if (bitCount == 5'h10) begin
               rxWord    <= shiftIn;
               frameDone <= 1'b1;
            end
         end
      end
   end
endmodule // smm_spi_shift

// file: smm_host.sv
// Host SPI master model for the monitor-mode block.
`timescale 1ns/1ps
module smm_host (
   // Clock and link pins.
   input  wire core_clk,
   input  wire miso,
   output reg  sclk,
   output reg  csDeploy_n,
   output reg  mosi
);
   initial begin
      sclk = 1'b0;
      csDeploy_n = 1'b1;
      mosi = 1'b0;
   end
   function faultFree(input [15:0] r);
      faultFree = !r[13] && !r[3];
   endfunction
   // =====
   // Frame transfer
   // Data is read just before each falling edge, so a slow output stage still meets it.
   task xfer(input [15:0] w, input bad, output [15:0] r);
      reg [15:0] f;
      integer    k;
      begin
         f = w;
         f[13] = ~^{w[15:14], w[12:0]} ^ bad;
         @(posedge core_clk);
         csDeploy_n <= 1'b0;
         mosi <= f[15];
         repeat (8) @(posedge core_clk);
         for (k = 15; k >= 0; k = k - 1) begin
            sclk <= 1'b1;
            repeat (4) @(posedge core_clk);
            r[k] = miso;
            sclk <= 1'b0;
            if (k > 0) mosi <= f[k - 1];
            repeat (4) @(posedge core_clk);
         end
         csDeploy_n <= 1'b1;
         mosi <= ~f[0];
         repeat (10) @(posedge core_clk);
      end
   endtask
endmodule // smm_host

// file: smm_monitor_mode_asserts.sv
// Port-level checks for the monitor-mode block.
`timescale 1ns/1ps
module smm_monitor_mode_chk #(
   parameter CHANNELS      = 8,
   parameter DEPLOY_CYCLES = 20
) (
   // Watched ports.
   input wire                core_clk,
   input wire                rst_n,
   input wire                csDeploy_n,
   input wire                misoEn,
   input wire [CHANNELS-1:0] deployActive,
   input wire [CHANNELS-1:0] deploySuccess,
   input wire                reportOr,
   input wire                analogMonitorEn,
   input wire [2:0]          monitorChannel,
   input wire                parityFault
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   reg [15:0] actLen;
   always @(posedge core_clk) begin
      if (!rst_n || !deployActive[0]) actLen <= 16'h0000;
      else actLen <= actLen + 16'h0001;
   end
   // =====
   // Checks
   reset_clear_a: assert property ($rose(rst_n) |-> deploySuccess == '0 && !reportOr)
      else $error("flags not cleared by reset");
   expiry_sets_a: assert property ($fell(deployActive[0]) |-> ##[0:2] deploySuccess[0])
      else $error("success flag missing after deployment");
   active_len_a: assert property ($fell(deployActive[0]) |->
      actLen >= DEPLOY_CYCLES - 1 && actLen <= DEPLOY_CYCLES + 1)
      else $error("deployment period length wrong");
   no_redeploy_a: assert property ($past(deploySuccess[0]) |-> !$rose(deployActive[0]))
      else $error("deployment started while success flag set");
   parity_hold_a: assert property ($rose(parityFault) |->
      ($stable(reportOr) && ($past(deploySuccess) & ~deploySuccess) == '0)[*3])
      else $error("bad parity frame changed state");
   clear_gap_a: assert property ((($past(deploySuccess) & ~deploySuccess) != '0) |-> csDeploy_n)
      else $error("success flag cleared inside a frame");
   select_gap_a: assert property ($changed(reportOr) |-> csDeploy_n && $past(csDeploy_n, 3))
      else $error("report select changed outside frame end");
   diag_gap_a: assert property ($changed(monitorChannel) || $changed(analogMonitorEn) |->
      csDeploy_n && $past(csDeploy_n, 3))
      else $error("monitor settings changed outside frame end");
   miso_idle_a: assert property (csDeploy_n [*4] |=> !misoEn)
      else $error("data output driven while deselected");
   miso_drive_a: assert property (!csDeploy_n [*4] |=> misoEn)
      else $error("data output not driven while selected");
endmodule // smm_monitor_mode_chk
bind smm_monitor_mode smm_monitor_mode_chk #(.CHANNELS(CHANNELS), .DEPLOY_CYCLES(DEPLOY_CYCLES)) chkU (
   .core_clk(core_clk), .rst_n(rst_n), .csDeploy_n(csDeploy_n), .misoEn(misoEn),
   .deployActive(deployActive), .deploySuccess(deploySuccess), .reportOr(reportOr),
   .analogMonitorEn(analogMonitorEn), .monitorChannel(monitorChannel), .parityFault(parityFault));

// file: smm_monitor_mode_tb.sv
// Self-checking bench for the monitor-mode block.
`timescale 1ns/1ps
module smm_monitor_mode_tb;
   typedef struct packed {logic [15:0] tx; logic [3:0] out; logic [15:0] resp;} smm_row_t;
   localparam DEPLOY = 300;
   reg        core_clk, rst_n, sqhAboveBat, overCurrent;
   reg  [7:0] deployRequest, sqlBelowGnd;
   wire       sclk, csDeploy_n, mosi, miso, misoEn, analogMonitorEn, reportOr, parityFault;
   wire [7:0] deployActive, deploySuccess;
   wire [2:0] monitorChannel;
   reg [15:0] rx;
   integer    i, errTotal, checkCount;
   smm_row_t  rows [0:8] = '{'{16'h9090, 4'h9, 16'hA088}, '{16'h9020, 4'h2, 16'hA008},
      '{16'h90B0, 4'hB, 16'hA088}, '{16'h9040, 4'h4, 16'hA088}, '{16'h90D0, 4'hD, 16'hA008},
      '{16'h9060, 4'h6, 16'hA088}, '{16'h90F0, 4'hF, 16'hA008}, '{16'h9000, 4'h0, 16'hA008},
      '{16'h8070, 4'h0, 16'hA008}};
   smm_monitor_mode #(.CHANNELS(8), .DEPLOY_CYCLES(DEPLOY)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .sclk(sclk), .csDeploy_n(csDeploy_n), .mosi(mosi), .miso(miso), .misoEn(misoEn),
      .deployRequest(deployRequest), .sqlBelowGnd(sqlBelowGnd), .sqhAboveBat(sqhAboveBat),
      .overCurrent(overCurrent), .deployActive(deployActive), .deploySuccess(deploySuccess),
      .reportOr(reportOr), .analogMonitorEn(analogMonitorEn), .monitorChannel(monitorChannel),
      .parityFault(parityFault));
   smm_host hostU (.core_clk(core_clk), .miso(miso), .sclk(sclk), .csDeploy_n(csDeploy_n), .mosi(mosi));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task tick(input integer n);
      repeat (n) @(posedge core_clk);
   endtask
   task chk(input string nm, input [15:0] exp, input [15:0] got);
      begin
         checkCount = checkCount + 1;
         if (got !== exp) begin
            errTotal = errTotal + 1;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
         end
      end
   endtask
   task sx(input [15:0] w, input [15:0] exp);
      begin
         hostU.xfer(w, 1'b0, rx);
         chk("resp", exp, rx);
      end
   endtask
   task finalReport;
      begin
         if (errTotal == 0 && checkCount > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   // =====
   // Main sequence
   initial begin
      errTotal = 0;
      checkCount = 0;
      rst_n = 1'b0;
      deployRequest = 8'h00;
      sqlBelowGnd = 8'h5A;
      sqhAboveBat = 1'b1;
      overCurrent = 1'b1;
      tick(6);
      rst_n <= 1'b1;
      tick(4);
      chk("flags", 16'h0000, {deploySuccess, reportOr, misoEn});
      sx(16'h4000, 16'h0000);
      for (i = 0; i < 9; i = i + 1) begin
         sx(rows[i].tx, i == 0 ? 16'h4000 : rows[i - 1].resp);
         chk("diag", {12'h000, rows[i].out}, {analogMonitorEn, monitorChannel});
      end
      // Quiet above-battery and over-current comparators: the host must see a fault-free diagnostic word.
      sqhAboveBat <= 1'b0;
      overCurrent <= 1'b0;
      tick(4);
      sx(16'h8000, 16'h8000);
      chk("nofault", 16'h0001, {15'h0000, hostU.faultFree(rx)});
      sqhAboveBat <= 1'b1;
      overCurrent <= 1'b1;
      deployRequest <= 8'h09;
      tick(6);
      chk("act", 16'h0009, deployActive);
      tick(DEPLOY + 10);
      chk("done", 16'h0009, {deployActive, deploySuccess});
      deployRequest <= 8'h00;
      tick(3);
      deployRequest <= 8'h09;
      tick(6);
      chk("inhibit", 16'h0000, deployActive);
      sx(16'hC000, rows[8].resp);
      deployRequest <= 8'h0B;
      sx(16'hC100, 16'hC009);
      sx(16'hC100, 16'hC00B);
      tick(DEPLOY);
      hostU.xfer(16'hC003, 1'b1, rx);
      chk("bad", 16'h0B03, {deploySuccess, 6'h00, reportOr, parityFault});
      hostU.xfer(16'hC003, 1'b0, rx);
      chk("clear", 16'h0800, {deploySuccess, 7'h00, reportOr});
      deployRequest <= 8'h0A;
      tick(3);
      deployRequest <= 8'h0B;
      tick(6);
      chk("again", 16'h0001, deployActive);
      sx(16'hC000, 16'hC008);
      rst_n <= 1'b0;
      tick(6);
      rst_n <= 1'b1;
      tick(4);
      chk("reset", 16'h0000, {deploySuccess, reportOr});
      sx(16'h4000, 16'h0000);
      finalReport;
   end
   initial begin
      tick(60000);
      errTotal = errTotal + 1;
      finalReport;
   end
endmodule // smm_monitor_mode_tb
